//--- src/sgq_regs.svh
`ifndef SGQ_REGS_SVH
`define SGQ_REGS_SVH
`define SGQ_CTRL_SUPPRESS_INT_BIT 7
`define SGQ_CTRL_SKIP_DATA_BIT    5
`define SGQ_CB_LIST_PTR_BYTE      8
`define SGQ_MAX_SEGMENTS          14'h2000
`define SGQ_STAT_OK               8'h00
`define SGQ_STAT_TAG_FLUSH        8'h24
`define SGQ_STAT_SCSI_RESET       8'h23
`define SGQ_ENTRY_BYTES_EXT       32'h0000_0008
`define SGQ_ENTRY_BYTES_LEG       32'h0000_0006
`define SGQ_NUM_TARGETS           8
`endif

//--- src/sgq_pkg.sv
package sgq_pkg;
  typedef enum logic [2:0] {
    SGQ_IDLE    = 3'h0,
    SGQ_FETCH   = 3'h1,
    SGQ_MOVE    = 3'h3,
    SGQ_DONE    = 3'h2,
    SGQ_FLUSH   = 3'h6
  } sgq_state_type;
  typedef enum logic [1:0] {
    SGQ_MSG_NONE  = 2'h0,
    SGQ_MSG_TAG   = 2'h1,
    SGQ_MSG_SYNC  = 2'h2,
    SGQ_MSG_ABORT = 2'h3
  } sgq_msg_type;
endpackage : sgq_pkg

//--- src/sgq_engine.sv
`include "sgq_regs.svh"
// How it works
// - Control bit 7 set: no completion interrupt; clear: interrupt on each completion.
// - Legacy entry: 3-byte length then 3-byte 24-bit address.
// - Extended entry: 4-byte count then 4-byte 32-bit pointer, LSB first.
// - List start address comes from command block bytes 8 to 11.
// - Lists of 1 to 8192 entries are accepted.
// - Extended mode uses full 32-bit pointers for DMA.
// - Abort of tagged block waits for reconnect with matching nexus.
// - Device reset completes every block of that target with reset status.
// - Bus reset flushes lists and completes target 0 and each target with tagged or aborting blocks, with reset status.
// - Untagged reconnect with tags outstanding: abort, flush target with status 24H.
// - Tag follows identify; own sync negotiation outranks the tag.
// - Auto sense on contingent allegiance issues request sense.
// - Control bit 5 set: no data moves to or from host memory.
module sgq_engine
  import sgq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        cmd_start,
  input  wire logic [7:0]  command_block_ctrl,
  input  wire logic [31:0] command_block_list_ptr,
  input  wire logic [13:0] command_block_seg_count,
  input  wire logic [2:0]  command_block_target,
  input  wire logic        command_block_tagged,
  input  wire logic        extended_mode,
  output logic             cmd_busy,
  output logic             mem_rd_req,
  output logic [31:0]      mem_rd_addr,
  input  wire logic        mem_rd_valid,
  input  wire logic [7:0]  mem_rd_byte,
  output logic             dma_req,
  output logic [31:0]      dma_addr,
  input  wire logic        dma_ack,
  input  wire logic        bus_reset,
  input  wire logic        dev_reset,
  input  wire logic [2:0]  dev_reset_target,
  input  wire logic        reconnect,
  input  wire logic [2:0]  reconnect_target,
  input  wire logic        reconnect_has_tag,
  input  wire logic        abort_req,
  input  wire logic        reconnect_tag_match,
  input  wire logic        contingent_allegiance,
  input  wire logic        auto_sense_en,
  input  wire logic        sync_neg_pending,
  input  wire logic        identify_sent,
  output logic             request_sense,
  output sgq_msg_type      msg_out,
  output logic             msg_valid,
  output logic             cmpl_valid,
  output logic [2:0]       cmpl_target,
  output logic [7:0]       adapter_status_code,
  output logic             host_irq,
  output logic             list_len_err
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] bus_reset_sync_reg;
  logic [1:0] dev_reset_sync_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bus_reset_sync_reg <= 2'h0;
      dev_reset_sync_reg <= 2'h0;
    end else begin
      bus_reset_sync_reg <= {bus_reset_sync_reg[0], bus_reset};
      dev_reset_sync_reg <= {dev_reset_sync_reg[0], dev_reset};
    end
  end
  wire logic bus_rst_s = bus_reset_sync_reg[1];
  wire logic dev_rst_s = dev_reset_sync_reg[1];
  logic bus_rst_d_reg;
  logic dev_rst_d_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bus_rst_d_reg <= 1'b0;
      dev_rst_d_reg <= 1'b0;
    end else begin
      bus_rst_d_reg <= bus_rst_s;
      dev_rst_d_reg <= dev_rst_s;
    end
  end
  wire logic bus_rst_ev = bus_rst_s && !bus_rst_d_reg;
  wire logic dev_rst_ev = dev_rst_s && !dev_rst_d_reg;

  // ****************************************
  // Descriptor walker
  // ****************************************
  sgq_state_type state_reg;
  logic [31:0]   entry_addr_reg;
  logic [13:0]   seg_left_reg;
  logic [3:0]    byte_idx_reg;
  logic [31:0]   seg_count_reg;
  logic [31:0]   seg_ptr_reg;
  logic [7:0]    ctrl_reg;
  logic [2:0]    target_reg;
  logic          ext_reg;
  logic          tag_flush_reg;
  wire logic [3:0] entry_len = ext_reg ? 4'h8 : 4'h6;
  wire logic [3:0] half_len  = ext_reg ? 4'h4 : 4'h3;
  wire logic       skip_data = ctrl_reg[`SGQ_CTRL_SKIP_DATA_BIT];
  // A device reset cuts the walk only when aimed at the walking target; a bus reset always does
  wire logic       flush_any = bus_rst_ev || tag_flush_reg ||
                               (dev_rst_ev && dev_reset_target == target_reg);
  wire logic       seg_ok    = command_block_seg_count != 14'h0000 &&
                               command_block_seg_count <= `SGQ_MAX_SEGMENTS;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg      <= SGQ_IDLE;
      entry_addr_reg <= 32'h0000_0000;
      seg_left_reg   <= 14'h0000;
      byte_idx_reg   <= 4'h0;
      seg_count_reg  <= 32'h0000_0000;
      seg_ptr_reg    <= 32'h0000_0000;
      ctrl_reg       <= 8'h00;
      target_reg     <= 3'h0;
      ext_reg        <= 1'b0;
      list_len_err   <= 1'b0;
    end else begin
      list_len_err <= 1'b0;
      unique case (state_reg)
        SGQ_IDLE: if (cmd_start) begin
          ctrl_reg       <= command_block_ctrl;
          target_reg     <= command_block_target;
          ext_reg        <= extended_mode;
          entry_addr_reg <= command_block_list_ptr;
          seg_left_reg   <= command_block_seg_count;
          byte_idx_reg   <= 4'h0;
          if (!seg_ok) begin
            list_len_err <= 1'b1;
            state_reg    <= SGQ_DONE;
          end else begin
            state_reg <= SGQ_FETCH;
          end
        end
        // Cut walk: no DONE completion; the flush queue reports the block unless a bus reset cuts an untagged block at a target other than 0
        SGQ_FETCH: if (flush_any) state_reg <= SGQ_FLUSH;
        else if (mem_rd_valid) begin
          // Little-endian assembly, LSB first
          if (byte_idx_reg < half_len)
            seg_count_reg[{byte_idx_reg[1:0], 3'h0} +: 8] <= mem_rd_byte;
          else
            seg_ptr_reg[{2'(byte_idx_reg - half_len), 3'h0} +: 8] <= mem_rd_byte;
          if (byte_idx_reg == entry_len - 4'h1) begin
            byte_idx_reg   <= 4'h0;
            entry_addr_reg <= entry_addr_reg + (ext_reg ? `SGQ_ENTRY_BYTES_EXT
                                                        : `SGQ_ENTRY_BYTES_LEG);
            state_reg      <= SGQ_MOVE;
          end else begin
            byte_idx_reg <= byte_idx_reg + 4'h1;
          end
          if (byte_idx_reg == 4'h0) begin
            seg_count_reg <= {24'h0, mem_rd_byte};
            seg_ptr_reg   <= 32'h0000_0000;
          end
        end
        SGQ_MOVE: if (flush_any) state_reg <= SGQ_FLUSH;
        else if (seg_count_reg == 32'h0 || skip_data || dma_ack) begin
          if (seg_count_reg > 32'h1 && !skip_data) begin
            seg_count_reg <= seg_count_reg - 32'h1;
            seg_ptr_reg   <= seg_ptr_reg + 32'h1;
          end else if (seg_left_reg == 14'h1) begin
            state_reg <= SGQ_DONE;
          end else begin
            seg_left_reg <= seg_left_reg - 14'h1;
            state_reg    <= SGQ_FETCH;
          end
        end
        SGQ_DONE:  state_reg <= SGQ_IDLE;
        SGQ_FLUSH: state_reg <= SGQ_IDLE;
        default:   state_reg <= SGQ_IDLE;
      endcase
    end
  end

  assign cmd_busy    = state_reg != SGQ_IDLE;
  assign mem_rd_req  = state_reg == SGQ_FETCH;
  assign mem_rd_addr = entry_addr_reg + {28'h0, byte_idx_reg};
  assign dma_req     = state_reg == SGQ_MOVE && seg_count_reg != 32'h0 && !skip_data;
  assign dma_addr    = ext_reg ? seg_ptr_reg : {8'h00, seg_ptr_reg[23:0]};

  // ****************************************
  // Tag queue bookkeeping per target
  // ****************************************
  logic [`SGQ_NUM_TARGETS-1:0] tagged_out_reg;
  logic [`SGQ_NUM_TARGETS-1:0] abort_wait_reg;
  logic [`SGQ_NUM_TARGETS-1:0] flush_pend_reg;
  logic [7:0]                  flush_stat_reg;
  wire logic untag_reconn = reconnect && !reconnect_has_tag &&
                            tagged_out_reg[reconnect_target];
  genvar t;
  generate
    for (t = 0; t < `SGQ_NUM_TARGETS; t++) begin : g_tgt
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          tagged_out_reg[t] <= 1'b0;
          abort_wait_reg[t] <= 1'b0;
        end else begin
          // A tagged block taken in the same cycle as a clear stays outstanding
          if (cmd_start && !cmd_busy && command_block_tagged && command_block_target == t)
            tagged_out_reg[t] <= 1'b1;
          else if (bus_rst_ev || (dev_rst_ev && dev_reset_target == t) ||
                   (untag_reconn && reconnect_target == t))
            tagged_out_reg[t] <= 1'b0;
          // Abort holds until the matching nexus returns or a bus reset clears it
          if (bus_rst_ev)
            abort_wait_reg[t] <= 1'b0;
          else if (abort_req && tagged_out_reg[t] && target_reg == t)
            abort_wait_reg[t] <= 1'b1;
          else if (reconnect && reconnect_tag_match && reconnect_target == t)
            abort_wait_reg[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // Flush queue: one completion per cycle, lowest pending target first
  logic [2:0] flush_idx;
  always_comb begin
    flush_idx = 3'h0;
    for (int i = `SGQ_NUM_TARGETS - 1; i >= 0; i--)
      if (flush_pend_reg[i]) flush_idx = 3'(i);
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      flush_pend_reg <= 8'h00;
      flush_stat_reg <= `SGQ_STAT_OK;
      tag_flush_reg  <= 1'b0;
    end else begin
      tag_flush_reg <= untag_reconn && reconnect_target == target_reg && cmd_busy;
      if (bus_rst_ev) begin
        flush_pend_reg <= tagged_out_reg | abort_wait_reg | 8'h01;
        flush_stat_reg <= `SGQ_STAT_SCSI_RESET;
      end else if (dev_rst_ev) begin
        flush_pend_reg[dev_reset_target] <= 1'b1;
        flush_stat_reg <= `SGQ_STAT_SCSI_RESET;
      end else if (untag_reconn) begin
        flush_pend_reg[reconnect_target] <= 1'b1;
        flush_stat_reg <= `SGQ_STAT_TAG_FLUSH;
      end else if (flush_pend_reg != 8'h00) begin
        flush_pend_reg[flush_idx] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Completion and message out
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmpl_valid          <= 1'b0;
      cmpl_target         <= 3'h0;
      adapter_status_code <= `SGQ_STAT_OK;
      host_irq            <= 1'b0;
    end else begin
      cmpl_valid <= 1'b0;
      host_irq   <= 1'b0;
      if (flush_pend_reg != 8'h00 && !bus_rst_ev && !dev_rst_ev && !untag_reconn) begin
        cmpl_valid          <= 1'b1;
        cmpl_target         <= flush_idx;
        adapter_status_code <= flush_stat_reg;
        host_irq            <= !ctrl_reg[`SGQ_CTRL_SUPPRESS_INT_BIT];
      end else if (state_reg == SGQ_DONE) begin
        cmpl_valid          <= 1'b1;
        cmpl_target         <= target_reg;
        adapter_status_code <= `SGQ_STAT_OK;
        host_irq            <= !ctrl_reg[`SGQ_CTRL_SUPPRESS_INT_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      msg_out       <= SGQ_MSG_NONE;
      msg_valid     <= 1'b0;
      request_sense <= 1'b0;
    end else begin
      msg_valid     <= 1'b0;
      msg_out       <= SGQ_MSG_NONE;
      request_sense <= contingent_allegiance && auto_sense_en;
      if (untag_reconn ||
          (reconnect && reconnect_tag_match && abort_wait_reg[reconnect_target])) begin
        msg_valid <= 1'b1;
        msg_out   <= SGQ_MSG_ABORT;
      end else if (identify_sent && sync_neg_pending) begin
        msg_valid <= 1'b1;
        msg_out   <= SGQ_MSG_SYNC;
      end else if (identify_sent && command_block_tagged) begin
        msg_valid <= 1'b1;
        msg_out   <= SGQ_MSG_TAG;
      end
    end
  end

endmodule : sgq_engine

//--- verification/sgq_engine_assertions.sv
// ****************************************
// Port checker for the list walker
// ****************************************
module sgq_engine_checker (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        cmd_start,
  input wire logic [7:0]  command_block_ctrl,
  input wire logic [31:0] command_block_list_ptr,
  input wire logic [13:0] command_block_seg_count,
  input wire logic        extended_mode,
  input wire logic        cmd_busy,
  input wire logic        mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic        mem_rd_valid,
  input wire logic        dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic        dma_ack,
  input wire logic        contingent_allegiance,
  input wire logic        auto_sense_en,
  input wire logic        request_sense,
  input wire logic        cmpl_valid,
  input wire logic        host_irq,
  input wire logic        list_len_err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sup_reg, skip_reg, ext_reg, bad_reg;
  wire  take = cmd_start && !cmd_busy;
  wire  bad  = command_block_seg_count == 14'h0 || command_block_seg_count > 14'h2000;
  // Settings of the accepted block, held until the next start
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      {sup_reg, skip_reg, ext_reg, bad_reg} <= 4'h0;
    end else if (take) begin
      {sup_reg, skip_reg, ext_reg, bad_reg} <=
        {command_block_ctrl[7], command_block_ctrl[5], extended_mode, bad};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence byte_in; mem_rd_req && mem_rd_valid; endsequence
  sequence dma_beat; dma_req && dma_ack; endsequence
  a_irq_follows_ctrl: assert property (cmpl_valid |-> host_irq == !sup_reg)
    else $error("irq disagrees with control bit");
  a_irq_only_cmpl: assert property (host_irq |-> cmpl_valid)
    else $error("irq without completion");
  a_legacy_addr_24: assert property (dma_req && !ext_reg |-> dma_addr[31:24] == 8'h00)
    else $error("legacy address above 24 bits");
  a_fetch_from_ptr: assert property (take && !bad |=> mem_rd_req &&
    mem_rd_addr == $past(command_block_list_ptr)) else $error("list fetch address wrong");
  a_len_err_cause: assert property (list_len_err |-> bad_reg)
    else $error("length error on a legal list");
  a_len_err_seen: assert property (take && bad |-> ##[1:3] list_len_err)
    else $error("illegal list length not flagged");
  a_list_ascends: assert property (byte_in ##1 mem_rd_req |->
    mem_rd_addr == $past(mem_rd_addr) + 32'h1) else $error("list read not ascending");
  a_data_ascends: assert property (dma_beat ##1 dma_req |->
    dma_addr == $past(dma_addr) + 32'h1) else $error("data address not ascending");
  a_skip_no_move: assert property (skip_reg |-> !dma_req)
    else $error("data moved with skip bit set");
  a_sense_on_ca: assert property (contingent_allegiance && auto_sense_en |=> request_sense)
    else $error("request sense missing");
  a_no_sense_off: assert property (!auto_sense_en |=> !request_sense)
    else $error("request sense while disabled");
endmodule : sgq_engine_checker

bind sgq_engine sgq_engine_checker u_chk (.sys_clk, .rst_b, .cmd_start, .command_block_ctrl,
  .command_block_list_ptr, .command_block_seg_count, .extended_mode, .cmd_busy, .mem_rd_req,
  .mem_rd_addr, .mem_rd_valid, .dma_req, .dma_addr, .dma_ack, .contingent_allegiance,
  .auto_sense_en, .request_sense, .cmpl_valid, .host_irq, .list_len_err);

//--- verification/sgq_mem_model.sv
// ****************************************
// Host memory seen by the list walker
// ****************************************
module sgq_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_rd_req,
  input  wire logic [31:0] mem_rd_addr,
  output logic             mem_rd_valid,
  output logic [7:0]       mem_rd_byte,
  input  wire logic        dma_req,
  output logic             dma_ack,
  input  wire logic [3:0]  slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:63];
  logic [3:0] wait_cnt = 4'h0;
  initial begin
    mem_rd_valid = 1'b0;
    mem_rd_byte = 8'h00;
    dma_ack = 1'b0;
  end
  // Idle data line flips so a stale byte is never mistaken for a fresh one
  always @(posedge sys_clk) begin
    mem_rd_valid <= 1'b0;
    dma_ack <= 1'b0;
    mem_rd_byte <= ~mem_rd_byte;
    if (mem_rd_req && !mem_rd_valid) begin
      if (wait_cnt >= slow) begin
        mem_rd_valid <= 1'b1;
        mem_rd_byte <= mem[mem_rd_addr[5:0]];
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
    if (dma_req && !dma_ack) dma_ack <= 1'b1;
  end
endmodule : sgq_mem_model

//--- verification/sg_list_tag_queue_handler_test.sv
`include "sgq_regs.svh"
// ****************************************
// Bench for the list walker and tag queue
// ****************************************
module sg_list_tag_queue_handler_test;
  timeunit 1ns;
  timeprecision 1ps;
  import sgq_pkg::*;
  localparam int DMA = 0, IRQ = 1, CMPL = 2, RS = 3, ERR = 4;
  logic        sys_clk, rst_b, cmd_start, command_block_tagged, extended_mode, cmd_busy;
  logic [7:0]  command_block_ctrl, mem_rd_byte, adapter_status_code, last_stat;
  logic [31:0] command_block_list_ptr, mem_rd_addr, dma_addr, dma_first, dma_last;
  logic [13:0] command_block_seg_count;
  logic [2:0]  command_block_target, dev_reset_target, reconnect_target, cmpl_target, last_tgt;
  logic        mem_rd_req, mem_rd_valid, dma_req, dma_ack, bus_reset, dev_reset, reconnect;
  logic        reconnect_has_tag, abort_req, reconnect_tag_match, contingent_allegiance;
  logic        auto_sense_en, sync_neg_pending, identify_sent, request_sense, msg_valid;
  logic        cmpl_valid, host_irq, list_len_err;
  logic [3:0]  slow;
  sgq_msg_type msg_out, last_msg;
  int          mismatches, samples_checked;
  int          cnt [0:4];
  sgq_engine uut (.sys_clk, .rst_b, .cmd_start, .command_block_ctrl, .command_block_list_ptr,
    .command_block_seg_count, .command_block_target, .command_block_tagged, .extended_mode,
    .cmd_busy, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_byte, .dma_req, .dma_addr,
    .dma_ack, .bus_reset, .dev_reset, .dev_reset_target, .reconnect, .reconnect_target,
    .reconnect_has_tag, .abort_req, .reconnect_tag_match, .contingent_allegiance,
    .auto_sense_en, .sync_neg_pending, .identify_sent, .request_sense, .msg_out, .msg_valid,
    .cmpl_valid, .cmpl_target, .adapter_status_code, .host_irq, .list_len_err);
  sgq_mem_model mdl (.sys_clk, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_byte,
    .dma_req, .dma_ack, .slow);
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (dma_req && dma_ack) begin
      if (cnt[DMA] == 0) dma_first <= dma_addr;
      dma_last <= dma_addr;
      cnt[DMA]++;
    end
    if (cmpl_valid) begin
      cnt[CMPL]++;
      last_stat <= adapter_status_code;
      last_tgt <= cmpl_target;
    end
    if (msg_valid) last_msg <= msg_out;
    cnt[IRQ] += host_irq;
    cnt[RS] += request_sense;
    cnt[ERR] += list_len_err;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : step
  task automatic do_reset(input int n);
    rst_b = 1'b0;
    step(n);
    rst_b = 1'b1;
    cnt = '{default: 0};
  endtask : do_reset
  // Entry: count bytes then pointer bytes, least significant first
  task automatic put(input int at, input int w, input logic [31:0] n, input logic [31:0] p);
    for (int i = 0; i < w; i++) begin
      mdl.mem[at + i] = n[8*i +: 8];
      mdl.mem[at + w + i] = p[8*i +: 8];
    end
  endtask : put
  task automatic run(input logic [7:0] c, input logic [13:0] s, input logic e, input logic t);
    command_block_ctrl = c;
    command_block_seg_count = s;
    extended_mode = e;
    command_block_tagged = t;
    cmd_start = 1'b1;
    step(1);
    cmd_start = 1'b0;
    for (int i = 0; i < 3000 && cmd_busy !== 1'b0 && !t; i++) step(1);
    step(t ? 4 : 3);
  endtask : run
  task automatic t_walks;
    do_reset(2);
    put(16, 4, 2, 32'h1234_5670);
    put(24, 4, 3, 32'hA000_0010);
    run(8'h00, 14'h2, 1'b1, 1'b0);
    check(cnt[DMA], 5);
    check(dma_first, 32'h1234_5670);
    check(dma_last, 32'hA000_0012);
    check(cnt[IRQ], 1);
    do_reset(2);
    slow = 4'h3;
    command_block_list_ptr = 32'h0000_0028;
    put(40, 3, 2, 32'hFF12_3456);
    run(8'h80, 14'h1, 1'b0, 1'b0);
    check(dma_last, 32'h0012_3457);
    check(cnt[IRQ], 32'h0);
    check(cnt[CMPL], 32'h1);
    do_reset(2);
    run(8'h20, 14'h1, 1'b0, 1'b0);
    check(cnt[DMA], 32'h0);
    check(cnt[CMPL], 32'h1);
    foreach (cnt[i]) begin
      do_reset(2);
      run(8'h00, i[0] ? 14'h2001 : 14'h0000, 1'b1, 1'b0);
      check(cnt[ERR], 32'h1);
      check(cnt[DMA], 32'h0);
    end
  endtask : t_walks
  // Resets and a tagless reconnect arriving while a tagged block is held up
  task automatic t_events;
    for (int k = 0; k < 3; k++) begin
      do_reset(2);
      slow = 4'hF;
      {command_block_target, dev_reset_target, reconnect_target} = 9'h092;
      run(8'h00, 14'h1, 1'b1, 1'b1);
      dev_reset = (k == 0);
      bus_reset = (k == 1);
      reconnect = (k == 2);
      step(1);
      reconnect = 1'b0;
      step(3);
      dev_reset = 1'b0;
      bus_reset = 1'b0;
      for (int i = 0; i < 60 && cnt[CMPL] == 0; i++) step(1);
      step(10);
      check(last_stat, k == 2 ? `SGQ_STAT_TAG_FLUSH : `SGQ_STAT_SCSI_RESET);
      check(last_tgt, 3'h2);
      check(cnt[CMPL], k == 1 ? 32'h2 : 32'h1);
      if (k == 2) check(last_msg, SGQ_MSG_ABORT);
    end
  endtask : t_events
  task automatic t_msgs;
    do_reset(2);
    run(8'h00, 14'h1, 1'b1, 1'b1);
    for (int k = 1; k >= 0; k--) begin
      sync_neg_pending = k[0];
      identify_sent = 1'b1;
      step(1);
      identify_sent = 1'b0;
      step(4);
      check(last_msg, k ? SGQ_MSG_SYNC : SGQ_MSG_TAG);
      auto_sense_en = k[0];
      contingent_allegiance = 1'b1;
      step(1);
      contingent_allegiance = 1'b0;
      step(2);
      check(cnt[RS], 1);
    end
    // Abort of a tagged block must wait for the matching reconnect
    abort_req = 1'b1;
    step(1);
    abort_req = 1'b0;
    step(3);
    check(last_msg, SGQ_MSG_TAG);
    {reconnect, reconnect_has_tag, reconnect_tag_match} = 3'h7;
    step(1);
    {reconnect, reconnect_has_tag, reconnect_tag_match} = 3'h0;
    step(3);
    check(last_msg, SGQ_MSG_ABORT);
  endtask : t_msgs
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  initial begin
    {cmd_start, command_block_tagged, extended_mode, bus_reset, dev_reset, reconnect} = 6'h0;
    {reconnect_has_tag, abort_req, reconnect_tag_match, contingent_allegiance} = 4'h0;
    {auto_sense_en, sync_neg_pending, identify_sent} = 3'h0;
    {command_block_ctrl, command_block_seg_count, slow} = 26'h0;
    command_block_list_ptr = 32'h0000_0010;
    {command_block_target, dev_reset_target, reconnect_target} = 9'h0B6;
    mismatches = 0;
    samples_checked = 0;
    do_reset(6);
    t_walks();
    t_events();
    t_msgs();
    wrap_up();
  end
  // Whole run needs well under 5000 cycles
  initial begin
    #500000;
    mismatches++;
    wrap_up();
  end
endmodule : sg_list_tag_queue_handler_test
